//--- tpc_regs.svh
// Register indices, field positions, reset values and event bits of the
// target pin and position compare block.
// Assumes a word-addressed map: byte address = index * 4.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Register indices
`define TPC_IDX_GENERAL_CONFIG   8'h00
`define TPC_IDX_REFERENCE_CONFIG 8'h01
`define TPC_IDX_EVENTS           8'h0E
`define TPC_IDX_FLAGS            8'h0F
`define TPC_IDX_COMPARE_VALUE    8'h32
`define TPC_IDX_EVENT_CLEAR      8'h70
`define TPC_IDX_EVENT_ENABLE     8'h71

// Byte address width of the register port
`define TPC_ADDR_W 10

// general_config fields
`define TPC_GC_INVERT_POL 16
`define TPC_GC_WEAK_PULL  17
`define TPC_GC_WIRED_AND  18

// reference_config fields
`define TPC_RC_PIN_SRC_LSB 0
`define TPC_RC_CMP_SOURCE  2
`define TPC_RC_PAIR_LSB    3

// Reset values
`define TPC_GC_RESET 32'h0000_0000
`define TPC_RC_RESET 32'h0000_0000
`define TPC_CV_RESET 32'h0000_0000
`define TPC_EV_RESET 3'h0

// Event bits
`define TPC_EV_W          3
`define TPC_EV_CMP_HIT    0
`define TPC_EV_TARGET_HIT 1
`define TPC_EV_ENC_FAULT  2

`endif

//--- tpc_pkg.sv
// Types shared by the target pin and position compare block.
// Assumes nothing beyond a SystemVerilog compiler.
package tpc_pkg;

  // Position words are signed microstep counts
  typedef logic signed [31:0] tpc_pos_t;

  // Operand pair of the comparator, in code order 00..11
  typedef enum logic [1:0] {TPC_PAIR_VALUE, TPC_PAIR_HOME, TPC_PAIR_LATCH, TPC_PAIR_REV} tpc_pair_t;

  // Flag forwarded to the target pin, in code order 00..11
  typedef enum logic [1:0] {TPC_SRC_TARGET, TPC_SRC_SPEED, TPC_SRC_ENC_FAULT, TPC_SRC_CMP_HIT} tpc_pin_src_t;

endpackage : tpc_pkg

//--- tpc_cmp_if.sv
// Bundle between the register block and the position comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface tpc_cmp_if;
  import tpc_pkg::*;
  logic      cmp_source;
  tpc_pair_t pair;
  tpc_pos_t  compare_value;
  tpc_pos_t  current_position;
  tpc_pos_t  encoder_position;
  tpc_pos_t  home_position;
  tpc_pos_t  latched_position;
  tpc_pos_t  latched_encoder_position;
  tpc_pos_t  revolution_count;
  logic      hit_flag;
  logic      hit_event;

  modport ctrl (output cmp_source, pair, compare_value, current_position, encoder_position,
                home_position, latched_position, latched_encoder_position, revolution_count,
                input hit_flag, hit_event);
  modport cmp  (input cmp_source, pair, compare_value, current_position, encoder_position,
                home_position, latched_position, latched_encoder_position, revolution_count,
                output hit_flag, hit_event);
endinterface : tpc_cmp_if
`default_nettype wire

//--- tpc_pos_comparator.sv
// Permanent position comparator: selects one operand pair, flags equality
// and raises a one-cycle event on a new equality or an encoder crossing.
// Assumes operands come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tpc_pos_comparator
  import tpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  tpc_cmp_if.cmp   cmp
);

  tpc_pos_t lhs;
  tpc_pos_t rhs;
  logic     equal;
  logic     crossing;
  tpc_pos_t prev_encoder;
  logic     prev_valid;

  // Operand selection; only the chosen pair can ever produce a hit [RULE11]
  always_comb begin
    lhs = cmp.cmp_source ? cmp.encoder_position : cmp.current_position;  // [RULE7] [RULE8]
    rhs = cmp.compare_value;                                             // Microsteps both sides [RULE9]
    case (cmp.pair)
      TPC_PAIR_VALUE: rhs = cmp.compare_value;
      TPC_PAIR_HOME:  rhs = cmp.home_position;                           // [RULE12]
      TPC_PAIR_LATCH: begin
        rhs = cmp.cmp_source ? cmp.latched_encoder_position : cmp.latched_position;  // [RULE12]
      end
      TPC_PAIR_REV: begin
        lhs = cmp.revolution_count;                                      // [RULE13]
        rhs = cmp.compare_value;
      end
      default: rhs = cmp.compare_value;
    endcase
  end

  // The encoder may skip values, so a jump over the target still counts [RULE10]
  assign equal    = (lhs == rhs);
  assign crossing = cmp.cmp_source && (cmp.pair != TPC_PAIR_REV) && prev_valid &&
                    (((prev_encoder < rhs) && (cmp.encoder_position > rhs)) ||
                     ((prev_encoder > rhs) && (cmp.encoder_position < rhs)));

  // Always running, no enable; flag follows equality, event marks a new one [RULE6] [RULE15]
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp.hit_flag  <= 1'b0;
      cmp.hit_event <= 1'b0;
      prev_encoder  <= '0;
      prev_valid    <= 1'b0;
    end else begin
      cmp.hit_flag  <= equal;
      cmp.hit_event <= (equal && !cmp.hit_flag) || crossing;
      prev_encoder  <= cmp.encoder_position;
      prev_valid    <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  internal_hit_a: assert property (!cmp.cmp_source && cmp.pair == TPC_PAIR_VALUE && // [RULE7]
      cmp.current_position == cmp.compare_value |=> cmp.hit_flag) else $error("internal equality not flagged");
  encoder_hit_a: assert property (cmp.cmp_source && cmp.pair == TPC_PAIR_VALUE && // [RULE8] [RULE9]
      cmp.encoder_position == cmp.compare_value |=> cmp.hit_flag) else $error("encoder equality not flagged");
  home_pair_a: assert property (!cmp.cmp_source && cmp.pair == TPC_PAIR_HOME && // [RULE12]
      cmp.current_position == cmp.home_position |=> cmp.hit_flag) else $error("home equality not flagged");
  rev_pair_a: assert property (cmp.pair == TPC_PAIR_REV && // [RULE13]
      cmp.revolution_count == cmp.compare_value |=> cmp.hit_flag) else $error("revolution equality not flagged");
  pair_only_a: assert property (!cmp.cmp_source && cmp.pair == TPC_PAIR_HOME && // [RULE11]
      cmp.current_position != cmp.home_position |=> !cmp.hit_flag) else $error("unselected pair raised hit");
  new_hit_event_a: assert property ($rose(cmp.hit_flag) |-> cmp.hit_event) // [RULE6]
    else $error("new equality raised no event");
  cross_event_a: assert property (cmp.cmp_source && cmp.pair == TPC_PAIR_VALUE && prev_valid && // [RULE10]
      prev_encoder < cmp.compare_value && cmp.encoder_position > cmp.compare_value
      |=> cmp.hit_event && !cmp.hit_flag) else $error("crossing not recorded");

endmodule : tpc_pos_comparator
`default_nettype wire

//--- tpc_target_compare.sv
// Target pin driver and register file of the position compare unit.
// Assumes all position and flag inputs come from logic on MCLK and that the
// pin pad turns TARGET_PIN_STRONG into strong or weak drive of TARGET_PIN_O.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_regs.svh"

// Behaviour
// RULE1: software enables weak drive before wired mode
// RULE2: weak drive, AND bit clear gives wired-OR
// RULE3: wired-OR: inactive weak, active strong
// RULE4: wired-AND: inactive strong, active weak
// RULE5: two-bit select routes one flag to pin
// RULE6: comparator always on, one flag, one event
// RULE7: source 0, pair 00: position versus value
// RULE8: source 1, pair 00: encoder versus value
// RULE9: encoder compare value is in microsteps
// RULE10: encoder jump over value still records event
// RULE11: only the selected pair can trigger
// RULE12: pair 01 home, pair 10 latch
// RULE13: pair 11 revolution count versus value
// RULE14: weak drive off means push-pull always
// RULE15: flag tracks equality, event latches until cleared
module tpc_target_compare
  import tpc_pkg::*;
(
  input  wire logic                   MCLK,
  input  wire logic                   SYS_RST,
  input  wire logic [`TPC_ADDR_W-1:0] ADDR,
  input  wire logic [31:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output var  logic [31:0]            RDATA,
  input  wire tpc_pos_t               CURRENT_POSITION,
  input  wire tpc_pos_t               GOAL_POSITION,
  input  wire tpc_pos_t               ENCODER_POSITION,
  input  wire tpc_pos_t               HOME_POSITION,
  input  wire tpc_pos_t               LATCHED_POSITION,
  input  wire tpc_pos_t               LATCHED_ENCODER_POSITION,
  input  wire tpc_pos_t               REVOLUTION_COUNT,
  input  wire logic                   SPEED_REACHED,
  input  wire logic                   ENCODER_FAULT_FLAG,
  output var  logic                   TARGET_PIN_O,
  output var  logic                   TARGET_PIN_OE_N,
  output var  logic                   TARGET_PIN_STRONG,
  output wire logic                   COMPARE_HIT_FLAG,
  output var  logic                   INTR
);

  // Byte address of a word register; used by both the write and read decode
  function automatic logic reg_hit(input logic [`TPC_ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction : reg_hit

  logic [31:0]           general_config;
  logic [31:0]           reference_config;
  tpc_pos_t              compare_value;
  logic [`TPC_EV_W-1:0]  event_status;
  logic [`TPC_EV_W-1:0]  event_enable;
  logic [`TPC_EV_W-1:0]  event_set;
  logic [`TPC_EV_W-1:0]  event_clear;
  logic                  target_hit;
  logic                  prev_enc_fault;
  logic                  invert_pol;
  logic                  weak_pull_drive_enable;
  logic                  wired_and_select;
  tpc_pin_src_t          pin_source;
  logic                  next_active;
  logic                  next_strong;

  tpc_cmp_if cmp_bus ();

  // Field views of the configuration words
  assign invert_pol             = general_config[`TPC_GC_INVERT_POL];
  assign weak_pull_drive_enable = general_config[`TPC_GC_WEAK_PULL];
  assign wired_and_select       = general_config[`TPC_GC_WIRED_AND];
  assign pin_source             = tpc_pin_src_t'(reference_config[`TPC_RC_PIN_SRC_LSB +: 2]);

  // Configuration writes; unmapped or read-only addresses are ignored
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      general_config   <= `TPC_GC_RESET;
      reference_config <= `TPC_RC_RESET;
      compare_value    <= `TPC_CV_RESET;
      event_enable     <= `TPC_EV_RESET;
    end else if (WR) begin
      if (reg_hit(ADDR, `TPC_IDX_GENERAL_CONFIG)) begin
        general_config <= WDATA;
      end
      if (reg_hit(ADDR, `TPC_IDX_REFERENCE_CONFIG)) begin
        reference_config <= WDATA;
      end
      if (reg_hit(ADDR, `TPC_IDX_COMPARE_VALUE)) begin
        compare_value <= WDATA;
      end
      if (reg_hit(ADDR, `TPC_IDX_EVENT_ENABLE)) begin
        event_enable <= WDATA[`TPC_EV_W-1:0];
      end
    end
  end

  // Comparator operands; the compare value is used as written, in microsteps
  assign cmp_bus.cmp_source               = reference_config[`TPC_RC_CMP_SOURCE];
  assign cmp_bus.pair                     = tpc_pair_t'(reference_config[`TPC_RC_PAIR_LSB +: 2]);
  assign cmp_bus.compare_value            = compare_value;   // [RULE9]
  assign cmp_bus.current_position         = CURRENT_POSITION;
  assign cmp_bus.encoder_position         = ENCODER_POSITION;
  assign cmp_bus.home_position            = HOME_POSITION;
  assign cmp_bus.latched_position         = LATCHED_POSITION;
  assign cmp_bus.latched_encoder_position = LATCHED_ENCODER_POSITION;
  assign cmp_bus.revolution_count         = REVOLUTION_COUNT;
  assign COMPARE_HIT_FLAG                 = cmp_bus.hit_flag;

  tpc_pos_comparator u_cmp (
    .clk (MCLK),
    .rst (SYS_RST),
    .cmp (cmp_bus)
  );

  // Target-hit flag and edge history of the event sources
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      target_hit     <= 1'b0;
      prev_enc_fault <= 1'b0;
    end else begin
      target_hit     <= (CURRENT_POSITION == GOAL_POSITION);
      prev_enc_fault <= ENCODER_FAULT_FLAG;
    end
  end

  // Event sources: compare event, target reached rising, encoder fault rising
  always_comb begin
    event_set                     = '0;
    event_set[`TPC_EV_CMP_HIT]    = cmp_bus.hit_event;
    event_set[`TPC_EV_TARGET_HIT] = (CURRENT_POSITION == GOAL_POSITION) && !target_hit;
    event_set[`TPC_EV_ENC_FAULT]  = ENCODER_FAULT_FLAG && !prev_enc_fault;
    event_clear                   = '0;
    if (WR && reg_hit(ADDR, `TPC_IDX_EVENT_CLEAR)) begin
      event_clear = WDATA[`TPC_EV_W-1:0];
    end
  end

  // Sticky events; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      event_status <= `TPC_EV_RESET;
    end else begin
      event_status <= (event_status & ~event_clear) | event_set;  // [RULE15] [RULE10]
    end
  end

  // Level interrupt while any enabled event is pending
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      INTR <= 1'b0;
    end else begin
      INTR <= |(event_status & event_enable);
    end
  end

  // Pin source and drive strength
  always_comb begin
    case (pin_source)                                      // [RULE5]
      TPC_SRC_TARGET:    next_active = target_hit;
      TPC_SRC_SPEED:     next_active = SPEED_REACHED;
      TPC_SRC_ENC_FAULT: next_active = ENCODER_FAULT_FLAG;
      TPC_SRC_CMP_HIT:   next_active = cmp_bus.hit_flag;
      default:           next_active = target_hit;
    endcase
    if (!weak_pull_drive_enable) begin
      next_strong = 1'b1;                                  // Push-pull [RULE14]
    end else if (!wired_and_select) begin
      next_strong = next_active;                           // Wired-OR [RULE2] [RULE3]
    end else begin
      next_strong = !next_active;                          // Wired-AND [RULE4]
    end
  end

  // Pin register; the pad only drives after reset to avoid a glitch on a shared line
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      TARGET_PIN_O      <= 1'b0;
      TARGET_PIN_OE_N   <= 1'b1;
      TARGET_PIN_STRONG <= 1'b0;
    end else begin
      TARGET_PIN_O      <= next_active ^ invert_pol;
      TARGET_PIN_OE_N   <= 1'b0;
      TARGET_PIN_STRONG <= next_strong;                    // [RULE2] [RULE3] [RULE4] [RULE14]
    end
  end

  // Read port; data stands for one cycle only, unmapped and write-only read zero
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      if (reg_hit(ADDR, `TPC_IDX_GENERAL_CONFIG)) begin
        RDATA <= general_config;
      end else if (reg_hit(ADDR, `TPC_IDX_REFERENCE_CONFIG)) begin
        RDATA <= reference_config;
      end else if (reg_hit(ADDR, `TPC_IDX_COMPARE_VALUE)) begin
        RDATA <= compare_value;
      end else if (reg_hit(ADDR, `TPC_IDX_EVENTS)) begin
        RDATA <= {29'h0000_0000, event_status};
      end else if (reg_hit(ADDR, `TPC_IDX_EVENT_ENABLE)) begin
        RDATA <= {29'h0000_0000, event_enable};
      end else if (reg_hit(ADDR, `TPC_IDX_FLAGS)) begin
        RDATA <= {28'h000_0000, cmp_bus.hit_flag, ENCODER_FAULT_FLAG, SPEED_REACHED, target_hit};
      end else begin
        RDATA <= 32'h0000_0000;
      end
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // Checked against whichever flag is routed, so the shared-line scenarios reach them
  wired_or_a: assert property (weak_pull_drive_enable && !wired_and_select // [RULE2] [RULE3]
      |=> TARGET_PIN_STRONG == $past(next_active))
    else $error("wired-OR strength wrong");
  wired_and_a: assert property (weak_pull_drive_enable && wired_and_select && // [RULE4]
      !next_active |=> TARGET_PIN_STRONG && TARGET_PIN_O == $past(invert_pol))
    else $error("wired-AND inactive not strong");
  push_pull_a: assert property (!weak_pull_drive_enable |=> TARGET_PIN_STRONG && !TARGET_PIN_OE_N) // [RULE14]
    else $error("push-pull not strong");
  pin_fault_src_a: assert property (pin_source == TPC_SRC_ENC_FAULT // [RULE5]
      |=> TARGET_PIN_O == ($past(ENCODER_FAULT_FLAG) ^ $past(invert_pol)))
    else $error("pin not forwarding fault flag");
  pin_cmp_src_a: assert property (pin_source == TPC_SRC_CMP_HIT ##1 pin_source == TPC_SRC_CMP_HIT // [RULE5] [RULE6]
      |=> TARGET_PIN_O == ($past(cmp_bus.hit_flag) ^ $past(invert_pol)))
    else $error("pin not forwarding compare flag");
  event_latch_a: assert property (cmp_bus.hit_event |=> event_status[`TPC_EV_CMP_HIT]) // [RULE15]
    else $error("compare event not latched");
  event_hold_a: assert property (event_status[`TPC_EV_CMP_HIT] && // [RULE15]
      !event_clear[`TPC_EV_CMP_HIT] |=> event_status[`TPC_EV_CMP_HIT])
    else $error("compare event lost without clear");
  irq_level_a: assert property (|(event_status & event_enable) |=> INTR) // [RULE6]
    else $error("interrupt not raised");

  wired_and_c: cover property (weak_pull_drive_enable && wired_and_select ##1 !TARGET_PIN_STRONG);
  cmp_event_c: cover property (cmp_bus.hit_event ##1 event_status[`TPC_EV_CMP_HIT]);
  irq_c:       cover property (INTR ##1 event_clear != '0 ##1 !INTR);

endmodule : tpc_target_compare
`default_nettype wire

//--- tpc_peer_pin.sv
// Model of a second controller whose target pin shares the signal line.
// Assumes high-active flags and that software has set weak drive before
// choosing a wired mode on both controllers.
`timescale 1ns/10ps
`default_nettype none
module tpc_peer_pin (
  input  wire logic peer_active,
  input  wire logic wired_and,
  input  wire logic dut_o,
  input  wire logic dut_oe_n,
  input  wire logic dut_strong,
  output var  logic line
);
  logic peer_strong;

  // Peer drives its active level strongly in wired-OR, its inactive level strongly in wired-AND
  assign peer_strong = wired_and ? !peer_active : peer_active; // Peer drive strength

  // Strong drive beats weak; contention between equal strengths gives an unknown so it is never missed
  always_comb begin
    if (!dut_oe_n && dut_strong && peer_strong) begin
      line = (dut_o == peer_active) ? dut_o : 1'bx;
    end else if (!dut_oe_n && dut_strong) begin
      line = dut_o;
    end else if (peer_strong || dut_oe_n || dut_o == peer_active) begin
      line = peer_active;
    end else begin
      line = 1'bx;
    end
  end
endmodule : tpc_peer_pin
`default_nettype wire

//--- target_pin_and_position_compare_tb_top.sv
// Self-checking bench for the target pin and position compare block.
// Assumes the register header, package, interface, design and peer model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module target_pin_and_position_compare_tb_top;
  import tpc_pkg::*;
  logic                   mclk, sys_rst, wr, rd, speed, fault, peer_act, wired_mode;
  logic [`TPC_ADDR_W-1:0] addr;
  logic [31:0]            wdata, rdata, rd_val;
  tpc_pos_t               cur, goal, enc, home, lat, lenc, rev;
  logic                   pin_o, pin_oe_n, pin_strong, hit, intr, line;
  int                     mismatches, checks;

  tpc_target_compare u_dut (.MCLK(mclk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CURRENT_POSITION(cur), .GOAL_POSITION(goal), .ENCODER_POSITION(enc),
    .HOME_POSITION(home), .LATCHED_POSITION(lat), .LATCHED_ENCODER_POSITION(lenc),
    .REVOLUTION_COUNT(rev), .SPEED_REACHED(speed), .ENCODER_FAULT_FLAG(fault), .TARGET_PIN_O(pin_o),
    .TARGET_PIN_OE_N(pin_oe_n), .TARGET_PIN_STRONG(pin_strong), .COMPARE_HIT_FLAG(hit), .INTR(intr));

  tpc_peer_pin u_peer (.peer_active(peer_act), .wired_and(wired_mode), .dut_o(pin_o),
    .dut_oe_n(pin_oe_n), .dut_strong(pin_strong), .line(line));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Edges pass, then one step so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // One-cycle write strobe; a gap cycle follows so strobes never collide
  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    @(posedge mclk);
    addr  <= {idx, 2'h0};
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] idx);
    @(posedge mclk);
    addr <= {idx, 2'h0};
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask : rd_reg

  // Mask bits in pin source order: target, speed, fault, compare hit (compare value is 0x46)
  task automatic set_flags(input logic [3:0] m);
    cur   <= m[3] ? 32'h46 : 32'h0A;
    goal  <= (m[3] ? 32'h46 : 32'h0A) + {31'h0, !m[0]};
    speed <= m[1];
    fault <= m[2];
  endtask : set_flags

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic t_reset();
    logic [7:0] idx [7] = '{`TPC_IDX_GENERAL_CONFIG, `TPC_IDX_REFERENCE_CONFIG, `TPC_IDX_COMPARE_VALUE,
      `TPC_IDX_EVENTS, `TPC_IDX_FLAGS, `TPC_IDX_EVENT_ENABLE, 8'h05};
    foreach (idx[i]) begin
      rd_reg(idx[i]);
      `CHK(rd_val, 32'h0) // All zero after reset, wired-OR default
    end
    `CHK(pin_oe_n, 1'b0) // Pin driven
    `CHK(pin_strong, 1'b1) // Push-pull while weak drive off
    wr_reg(`TPC_IDX_EVENTS, 32'hFFFF_FFFF);
    wr_reg(`TPC_IDX_COMPARE_VALUE, 32'h46);
    rd_reg(`TPC_IDX_EVENTS);
    `CHK(rd_val, 32'h0) // Read-only events ignore writes
    rd_reg(`TPC_IDX_COMPARE_VALUE);
    `CHK(rd_val, 32'h46) // Compare value kept
    $display("test reset done");
  endtask : t_reset

  task automatic t_pin_source();
    for (int s = 0; s < 4; s++) begin
      wr_reg(`TPC_IDX_REFERENCE_CONFIG, 32'(s));
      set_flags(~(4'h1 << s));
      tick(4);
      `CHK(pin_o, 1'b0) // Unselected flags stay off the pin
      set_flags(4'h1 << s);
      tick(4);
      `CHK(pin_o, 1'b1) // Selected flag reaches the pin
    end
    wr_reg(`TPC_IDX_GENERAL_CONFIG, 32'h0001_0000);
    tick(3);
    `CHK(pin_o, 1'b0) // Inverted polarity
    wr_reg(`TPC_IDX_GENERAL_CONFIG, 32'h0);
    $display("test pin source done");
  endtask : t_pin_source

  task automatic t_wired();
    wr_reg(`TPC_IDX_REFERENCE_CONFIG, 32'h0);
    wr_reg(`TPC_IDX_GENERAL_CONFIG, 32'h0002_0000); // Weak drive first
    for (int m = 0; m < 2; m++) begin
      wr_reg(`TPC_IDX_GENERAL_CONFIG, m ? 32'h0006_0000 : 32'h0002_0000);
      wired_mode <= m[0];
      for (int c = 0; c < 4; c++) begin
        set_flags({3'h0, c[0]});
        peer_act <= c[1];
        tick(4);
        `CHK(pin_strong, logic'(m ? !c[0] : c[0])) // Drive strength per mode
        `CHK(line, logic'(m ? c[0] & c[1] : c[0] | c[1])) // Shared line level
      end
    end
    wr_reg(`TPC_IDX_GENERAL_CONFIG, 32'h0004_0000);
    for (int c = 0; c < 2; c++) begin
      set_flags({3'h0, c[0]});
      tick(4);
      `CHK(pin_strong, 1'b1) // AND bit ignored without weak drive
      `CHK(pin_o, c[0]) // Push-pull level
    end
    $display("test wired done");
  endtask : t_wired

  task automatic t_compare();
    tpc_pos_t v;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr_reg(`TPC_IDX_REFERENCE_CONFIG, {27'h0, p[1:0], s[0], 2'h0});
        // A decoy pair is equal but not selected
        cur <= (s == 0 && p == 0) ? 32'h0A : 32'h46;
        enc <= (s == 0 && p == 0) ? 32'h46 : 32'h14;
        rev <= 32'h3C;
        tick(4);
        wr_reg(`TPC_IDX_EVENT_CLEAR, 32'h7);
        tick(2);
        `CHK(hit, 1'b0) // Unselected pair cannot hit
        rd_reg(`TPC_IDX_EVENTS);
        `CHK(rd_val[0], 1'b0) // No event from unselected pair
        v = (p == 1) ? 32'h1E : (p == 2) ? (s ? 32'h32 : 32'h28) : 32'h46;
        if (p == 3) rev <= v;
        else if (s == 1) enc <= v;
        else cur <= v;
        tick(4);
        `CHK(hit, 1'b1) // Selected pair equal
        rd_reg(`TPC_IDX_EVENTS);
        `CHK(rd_val[0], 1'b1) // Event recorded
        wr_reg(`TPC_IDX_EVENT_CLEAR, 32'h1);
        tick(3);
        rd_reg(`TPC_IDX_EVENTS);
        `CHK(rd_val[0], 1'b0) // One event per new equality
        `CHK(hit, 1'b1) // Flag holds while equal
      end
    end
    $display("test compare done");
  endtask : t_compare

  task automatic t_cross_intr();
    wr_reg(`TPC_IDX_REFERENCE_CONFIG, 32'h4);
    wr_reg(`TPC_IDX_COMPARE_VALUE, 32'h64);
    enc <= 32'h5A;
    tick(4);
    wr_reg(`TPC_IDX_EVENT_CLEAR, 32'h7);
    wr_reg(`TPC_IDX_EVENT_ENABLE, 32'h1);
    tick(3);
    `CHK(intr, 1'b0) // Quiet before crossing
    enc <= 32'h6E;
    tick(4);
    `CHK(hit, 1'b0) // Jump over value is no hit
    `CHK(intr, 1'b1) // Crossing event interrupts
    rd_reg(`TPC_IDX_EVENTS);
    `CHK(rd_val[0], 1'b1) // Crossing recorded
    wr_reg(`TPC_IDX_EVENT_CLEAR, 32'h1);
    tick(3);
    `CHK(intr, 1'b0) // Cleared event drops interrupt
    wr_reg(`TPC_IDX_EVENT_ENABLE, 32'h0);
    enc <= 32'h5A;
    tick(4);
    `CHK(intr, 1'b0) // Masked event stays silent
    rd_reg(`TPC_IDX_EVENTS);
    `CHK(rd_val[0], 1'b1) // Downward crossing recorded
    $display("test crossing done");
  endtask : t_cross_intr

  // Main sequence: two reset cycles, then every scenario
  initial begin
    {sys_rst, wr, rd, speed, fault, peer_act, wired_mode} = 7'h40;
    {addr, wdata, mismatches, checks} = '0;
    {cur, goal, enc, home} = {32'h0A, 32'h0B, 32'h14, 32'h1E};
    {lat, lenc, rev} = {32'h28, 32'h32, 32'h3C};
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(2);
    t_reset();
    t_pin_source();
    t_wired();
    t_compare();
    t_cross_intr();
    close_out();
  end

  // Hang guard at 90000 cycles, far beyond the run
  initial begin
    #900000;
    mismatches++;
    close_out();
  end
endmodule : target_pin_and_position_compare_tb_top
`default_nettype wire
